// ---- verilog/ewf_pkg.sv ----
// Package of constants and types for the wake-up frame filter
package ewf_pkg;
	localparam int         NUM_FILTERS      = 4;
	localparam int         MASK_BYTES       = 31;
	localparam logic [7:0] ADDR_PATTERN_BASE = 8'h28;
	localparam logic [7:0] ADDR_WAKE_CTRL   = 8'h2c;
	localparam logic [7:0] ADDR_SLEEP_CMD   = 8'h30;
	localparam int         WAKE_FRAME_BIT   = 6;
	localparam int         WAKE_SIG_BIT     = 5;
	localparam int         FRAME_EN_BIT     = 2;
	localparam int         SIG_EN_BIT       = 1;
	localparam int         IRQ_EN_BIT       = 0;
	localparam int         IRQ_FLAG_BIT     = 7;
	localparam int         SLEEP_BIT        = 8;
	localparam int         CMD_MCAST_BIT    = 3;
	localparam int         CMD_EN_BIT       = 0;
	localparam logic [3:0] SLEEP_ENTER_CODE = 4'hc;
	localparam logic [3:0] SLEEP_EXIT_CODE  = 4'hd;
	localparam logic [15:0] CRC_POLY        = 16'h8005;
	localparam logic [15:0] CRC_INIT        = 16'hffff;
	localparam logic [7:0] SIG_SYNC_BYTE    = 8'hff;
	localparam int         SIG_SYNC_COUNT   = 6;
	localparam int         SIG_REPEATS      = 16;
	localparam logic [31:0] REG_RESET       = 32'h0000_0000;
	localparam int         FIFO_DEPTH       = 16;
	typedef enum logic [1:0] {EWF_SIG_SYNC, EWF_SIG_ADDR} ewf_sig_e;
endpackage

// ---- verilog/ewf_fifo.sv ----
// Byte FIFO between the receive datapath and the wake-up filters
`timescale 1ns/1ps
module ewf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic [WIDTH-1:0]      o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = $clog2(DEPTH);
	// Pointer wrap arithmetic only works for power-of-two depths
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ewf_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic             full;
	logic             empty;
	assign full    = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty   = wp_r == rp_r;
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data  = mem[rp_r[AW-1:0]];
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (i_valid && !full)
				wp_r <= wp_r + 1'b1;
			if (i_ready && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_valid && !full)
			mem[wp_r[AW-1:0]] <= i_data;
	end
endmodule

// ---- verilog/ewf_top.sv ----
// Sleep-mode wake-up frame recognizer with pattern filters
`timescale 1ns/1ps
// Overview of operation
// - Only enabled signature or pattern frames wake
// - Pattern match plus address pass unless bypassed
// - Command MSB selects unicast or multicast
// - Command LSB enables each filter
// - Offset gives first examined frame byte
// - Masked bytes in window feed CRC
// - Mask bit 31 never selects a byte
// - Match when CRC equals programmed value
// - Wake frame sets status bit six
// - Interrupt only when interrupt enable set
// - Eight filter words in fixed order
// - Enabling a wake source also sleeps
module ewf_top (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	input  wire logic [3:0]  I_SLEEP_CMD,
	input  wire logic        I_SLEEP_CMD_WR,
	input  wire logic [47:0] I_STATION_ADDR,
	input  wire logic        I_RX_SOF,
	input  wire logic        I_RX_VALID,
	input  wire logic [7:0]  I_RX_DATA,
	input  wire logic        I_RX_EOF,
	input  wire logic        I_ADDR_PASS,
	input  wire logic        I_MCAST,
	input  wire logic        I_ADDRESS_FILTER_BYPASS,
	output logic             O_RX_READY,
	output logic [31:0]      O_RDATA,
	output logic             O_SLEEP,
	output logic             O_WAKE,
	output logic             O_POWER_EVENT_IRQ
);
	import ewf_pkg::*;
	typedef struct packed {
		logic [7:0][31:0]  pat;
		logic [8:0]        ctrl;
		logic              cmd_sleep;
		logic [NUM_FILTERS-1:0][15:0] crc;
		logic [NUM_FILTERS-1:0]       done;
		logic [10:0]       pos;
		logic              mcast;
		logic              apass;
		ewf_sig_e          sig_st;
		logic [2:0]        sig_n;
		logic [2:0]        sig_b;
		logic [4:0]        sig_rep;
		logic              sig_hit;
		logic [31:0]       rdata;
		logic              wake;
		logic              irq;
	} ewf_state_s;
	ewf_state_s s_r;
	ewf_state_s s_nxt;
	logic [8:0] f_data;
	logic       f_valid;
	logic       f_ready;
	// Start-of-frame mark travels with the byte: bit 8 = start of frame; end of frame is delayed two cycles outside the FIFO
	ewf_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RESET_N),
		.i_data  ({I_RX_SOF, I_RX_DATA}),
		.i_valid (I_RX_VALID),
		.o_ready (f_ready),
		.o_data  (f_data),
		.o_valid (f_valid),
		.i_ready (1'b1)
	);
	logic eof_d_r;
	logic eof_d2_r;
	always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			eof_d_r  <= 1'b0;
			eof_d2_r <= 1'b0;
		end else begin
			eof_d_r  <= I_RX_EOF;
			eof_d2_r <= eof_d_r;
		end
	end
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
	                                        input logic [7:0] b);
		logic [15:0] x;
		x = c;
		for (int k = 7; k >= 0; k--) begin
			if (x[15] ^ b[k])
				x = {x[14:0], 1'b0} ^ CRC_POLY;
			else
				x = {x[14:0], 1'b0};
		end
		return x;
	endfunction
	always_comb begin
		logic [7:0]  byt;
		logic        sof;
		logic [10:0] p;
		logic [7:0]  off;
		logic [3:0]  cmd;
		logic [10:0] rel;
		logic        frame_hit;
		logic        wake_ev;
		logic [7:0]  addr_byte;
		logic        frame_set;
		logic        sig_set;
		s_nxt     = s_r;
		frame_set = 1'b0;
		sig_set   = 1'b0;
		byt       = f_data[7:0];
		sof       = f_data[8];
		p         = '0;
		off       = '0;
		cmd       = '0;
		rel       = '0;
		frame_hit = 1'b0;
		wake_ev   = 1'b0;
		addr_byte = '0;
		s_nxt.wake = 1'b0;
		if (f_valid) begin
			if (sof) begin
				p = '0;
				s_nxt.crc     = {NUM_FILTERS{CRC_INIT}};
				s_nxt.done    = '0;
				s_nxt.sig_st  = EWF_SIG_SYNC;
				s_nxt.sig_n   = '0;
				s_nxt.sig_hit = 1'b0;
			end else begin
				p = s_r.pos;
			end
			if (p == 11'd0) begin
				s_nxt.mcast = I_MCAST;
				s_nxt.apass = I_ADDR_PASS;
			end
			for (int f = 0; f < NUM_FILTERS; f++) begin
				off = s_r.pat[5][8*f +: 8];
				rel = p - {3'b0, off};
				if (p >= {3'b0, off} && rel < 11'(MASK_BYTES) &&
				    s_r.pat[f][rel[4:0]] && rel[4:0] != 5'd31)
					s_nxt.crc[f] = crc_byte(sof ? CRC_INIT : s_r.crc[f], byt);
				if (p >= {3'b0, off} && rel == 11'(MASK_BYTES - 1))
					s_nxt.done[f] = 1'b1;
			end
			// Signature search restarts whenever the sequence breaks
			addr_byte = I_STATION_ADDR[47 - 8*s_r.sig_b -: 8];
			case (s_r.sig_st)
				EWF_SIG_SYNC: begin
					if (byt == SIG_SYNC_BYTE) begin
						if (s_r.sig_n == 3'(SIG_SYNC_COUNT - 1)) begin
							s_nxt.sig_st  = EWF_SIG_ADDR;
							s_nxt.sig_b   = '0;
							s_nxt.sig_rep = '0;
						end else begin
							s_nxt.sig_n = s_r.sig_n + 3'd1;
						end
					end else begin
						s_nxt.sig_n = '0;
					end
				end
				EWF_SIG_ADDR: begin
					if (byt == addr_byte) begin
						if (s_r.sig_b == 3'd5) begin
							s_nxt.sig_b = '0;
							if (s_r.sig_rep == 5'(SIG_REPEATS - 1))
								s_nxt.sig_hit = 1'b1;
							else
								s_nxt.sig_rep = s_r.sig_rep + 5'd1;
						end else begin
							s_nxt.sig_b = s_r.sig_b + 3'd1;
						end
					end else begin
						s_nxt.sig_st = EWF_SIG_SYNC;
						s_nxt.sig_n  = (byt == SIG_SYNC_BYTE) ? 3'd1 : 3'd0;
					end
				end
				default: s_nxt.sig_st = EWF_SIG_SYNC;
			endcase
			s_nxt.pos = (p == 11'h7ff) ? p : p + 11'd1;
		end
		// Decision at end of frame, after the FIFO has drained
		if (eof_d2_r && !f_valid) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				cmd = s_r.pat[4][8*f +: 4];
				if (cmd[CMD_EN_BIT] &&
				    cmd[CMD_MCAST_BIT] == s_r.mcast &&
				    s_r.done[f] &&
				    s_r.crc[f] == s_r.pat[6 + f/2][16*(f%2) +: 16])
					frame_hit = 1'b1;
			end
			frame_hit = frame_hit &&
			            (s_r.apass || I_ADDRESS_FILTER_BYPASS);
			if (s_r.ctrl[SLEEP_BIT] && frame_hit &&
			    s_r.ctrl[FRAME_EN_BIT]) begin
				s_nxt.ctrl[WAKE_FRAME_BIT] = 1'b1;
				frame_set = 1'b1;
				wake_ev = 1'b1;
			end
			if (s_r.ctrl[SLEEP_BIT] && s_r.sig_hit &&
			    s_r.ctrl[SIG_EN_BIT]) begin
				s_nxt.ctrl[WAKE_SIG_BIT] = 1'b1;
				sig_set = 1'b1;
				wake_ev = 1'b1;
			end
		end
		// Register writes; hardware set wins over software clear
		if (I_WR) begin
			if (I_ADDR >= ADDR_PATTERN_BASE &&
			    I_ADDR < ADDR_PATTERN_BASE + 8'd32 && I_ADDR[1:0] == 2'b00)
				s_nxt.pat[I_ADDR[4:2] - 3'd2] = I_WDATA;
			if (I_ADDR == ADDR_WAKE_CTRL) begin
				s_nxt.ctrl[2:0] = I_WDATA[2:0];
				if (!I_WDATA[WAKE_SIG_BIT] && !sig_set)
					s_nxt.ctrl[WAKE_SIG_BIT] = 1'b0;
				if (!I_WDATA[WAKE_FRAME_BIT] && !frame_set)
					s_nxt.ctrl[WAKE_FRAME_BIT] = 1'b0;
				if (!I_WDATA[IRQ_FLAG_BIT])
					s_nxt.ctrl[IRQ_FLAG_BIT] = 1'b0;
			end
		end
		for (int f = 0; f < NUM_FILTERS; f++)
			s_nxt.pat[f][31] = 1'b0;
		if (I_SLEEP_CMD_WR && I_SLEEP_CMD == SLEEP_ENTER_CODE)
			s_nxt.cmd_sleep = 1'b1;
		if (I_SLEEP_CMD_WR && I_SLEEP_CMD == SLEEP_EXIT_CODE)
			s_nxt.cmd_sleep = 1'b0;
		if (wake_ev) begin
			s_nxt.cmd_sleep = 1'b0;
			s_nxt.wake      = 1'b1;
			if (s_r.ctrl[IRQ_EN_BIT])
				s_nxt.ctrl[IRQ_FLAG_BIT] = 1'b1;
		end
		// Sleep holds while a source is armed and no wake has been seen
		s_nxt.ctrl[SLEEP_BIT] = s_nxt.cmd_sleep ||
			((s_nxt.ctrl[FRAME_EN_BIT] || s_nxt.ctrl[SIG_EN_BIT]) &&
			 !s_nxt.ctrl[WAKE_FRAME_BIT] && !s_nxt.ctrl[WAKE_SIG_BIT]);
		s_nxt.irq = s_nxt.ctrl[IRQ_FLAG_BIT];
		s_nxt.rdata = '0;
		if (I_RD) begin
			if (I_ADDR >= ADDR_PATTERN_BASE &&
			    I_ADDR < ADDR_PATTERN_BASE + 8'd32 && I_ADDR[1:0] == 2'b00)
				s_nxt.rdata = s_r.pat[I_ADDR[4:2] - 3'd2];
			else if (I_ADDR == ADDR_WAKE_CTRL)
				s_nxt.rdata = {23'b0, s_r.ctrl};
		end
	end
	always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	logic ready_r;
	always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N)
			ready_r <= 1'b0;
		else
			ready_r <= f_ready;
	end
	assign O_RX_READY        = ready_r;
	assign O_RDATA           = s_r.rdata;
	assign O_SLEEP           = s_r.ctrl[SLEEP_BIT];
	assign O_WAKE            = s_r.wake;
	assign O_POWER_EVENT_IRQ = s_r.irq;
endmodule

// ---- testbench/ewf_top_props.sv ----
// Concurrent checks on the wake-up filter top ports
`timescale 1ns/1ps
module ewf_top_props (
	input wire logic        I_REF_CLK,
	input wire logic        I_RESET_N,
	input wire logic [7:0]  I_ADDR,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic [3:0]  I_SLEEP_CMD,
	input wire logic        I_SLEEP_CMD_WR,
	input wire logic [31:0] O_RDATA,
	input wire logic        O_SLEEP,
	input wire logic        O_WAKE,
	input wire logic        O_POWER_EVENT_IRQ
);
	import ewf_pkg::*;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence mask_rd_s; I_RD && I_ADDR == ADDR_PATTERN_BASE; endsequence
	sequence wake_s; O_WAKE ##1 !O_WAKE; endsequence
	AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 32'h0)
		else $error("read data not zero outside a read");
	AST_MASK_TOP: assert property (mask_rd_s |=> !O_RDATA[31])
		else $error("mask bit 31 read as one");
	AST_ENTER: assert property (I_SLEEP_CMD_WR &&
		I_SLEEP_CMD == SLEEP_ENTER_CODE |=> O_SLEEP)
		else $error("sleep command did not enter sleep");
	AST_WAKE_PULSE: assert property (O_WAKE |-> wake_s)
		else $error("wake pulse longer than one cycle");
	AST_WAKE_SLEPT: assert property (O_WAKE |-> $past(O_SLEEP))
		else $error("wake while awake");
	AST_WAKE_ENDS: assert property (O_WAKE |-> ##[0:1] !O_SLEEP)
		else $error("wake did not end sleep");
	AST_IRQ_CAUSE: assert property ($rose(O_POWER_EVENT_IRQ) |->
		O_WAKE || $past(O_WAKE))
		else $error("irq without wake");
	AST_IRQ_KEEP: assert property (O_POWER_EVENT_IRQ &&
		!(I_WR && I_ADDR == ADDR_WAKE_CTRL) |=> O_POWER_EVENT_IRQ)
		else $error("irq flag cleared by itself");
	AST_SLEEP_FALL: assert property ($fell(O_SLEEP) |-> O_WAKE ||
		$past(O_WAKE) || $past(I_SLEEP_CMD_WR) || $past(I_WR))
		else $error("sleep left without cause");
endmodule
bind ewf_top ewf_top_props u_props (.I_REF_CLK(I_REF_CLK),
	.I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
	.I_SLEEP_CMD(I_SLEEP_CMD), .I_SLEEP_CMD_WR(I_SLEEP_CMD_WR),
	.O_RDATA(O_RDATA), .O_SLEEP(O_SLEEP), .O_WAKE(O_WAKE),
	.O_POWER_EVENT_IRQ(O_POWER_EVENT_IRQ));

// ---- testbench/ewf_mac_rx_model.sv ----
// Receive datapath model feeding frames byte by byte
`timescale 1ns/1ps
module ewf_mac_rx_model (
	input  wire logic i_clk,
	input  wire logic i_ready,
	output logic      o_sof,
	output logic      o_valid,
	output logic [7:0] o_data,
	output logic      o_eof,
	output logic      o_addr_pass,
	output logic      o_mcast
);
	logic [7:0] frame [128];
	initial begin
		{o_sof, o_valid, o_eof, o_addr_pass, o_mcast} = '0;
		o_data = 8'h00;
	end
	task automatic send(input int len, input logic pass, input int gap);
		for (int i = 0; i < len; i++) begin
			@(posedge i_clk);
			while (!i_ready)
				@(posedge i_clk);
			o_valid <= 1'b1;
			o_sof <= (i == 0);
			o_data <= frame[i];
			o_addr_pass <= pass;
			o_mcast <= frame[0][0];
			@(posedge i_clk);
			o_valid <= 1'b0;
			o_sof <= 1'b0;
			// Stale byte is inverted so nothing reads it as held
			o_data <= ~frame[i];
			repeat (gap) @(posedge i_clk);
		end
		o_eof <= 1'b1;
		@(posedge i_clk);
		o_eof <= 1'b0;
	endtask
endmodule

// ---- testbench/ewf_top_tb.sv ----
// Self-checking bench for the wake-up frame filter
`timescale 1ns/1ps
module ewf_top_tb;
	import ewf_pkg::*;
	logic        clk, rst_n, wr, rd, scw, byp, sof, vld, eof, pas, mc;
	logic        rdy, slp, wk, irq, en, cm, fm, ps, bp, ok, ie, ex, saw;
	logic [7:0]  addr, dat, off;
	logic [3:0]  scmd;
	logic [31:0] wd, rdat, m;
	logic [31:0] v [8];
	logic [15:0] lf;
	int          n_errors, compares;
	always #2.5 clk = ~clk;
	ewf_top DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
		.I_WDATA(wd), .I_WR(wr), .I_RD(rd), .I_SLEEP_CMD(scmd),
		.I_SLEEP_CMD_WR(scw), .I_STATION_ADDR(48'h0200_0000_0001),
		.I_RX_SOF(sof), .I_RX_VALID(vld), .I_RX_DATA(dat), .I_RX_EOF(eof),
		.I_ADDR_PASS(pas), .I_MCAST(mc), .I_ADDRESS_FILTER_BYPASS(byp),
		.O_RX_READY(rdy), .O_RDATA(rdat), .O_SLEEP(slp), .O_WAKE(wk),
		.O_POWER_EVENT_IRQ(irq));
	ewf_mac_rx_model PM (.i_clk(clk), .i_ready(rdy), .o_sof(sof),
		.o_valid(vld), .o_data(dat), .o_eof(eof), .o_addr_pass(pas),
		.o_mcast(mc));
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [15:0] crc(input logic [7:0] o, input logic [31:0] k);
		logic [15:0] c;
		c = CRC_INIT;
		for (int j = 0; j < MASK_BYTES; j++)
			if (k[j])
				for (int b = 7; b >= 0; b--)
					c = {c[14:0], 1'b0} ^ ((c[15] ^ PM.frame[o+j][b]) ? CRC_POLY : 16'h0);
		return c;
	endfunction
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk32({31'h0, g}, {31'h0, e});
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk32(rdat, e);
	endtask
	task automatic sleep_cmd(input logic [3:0] c, input logic e);
		@(posedge clk);
		scmd <= c;
		scw <= 1'b1;
		@(posedge clk);
		scw <= 1'b0;
		#1 chk1(slp, e);
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		n_errors++;
		wrap_up();
	end
	initial begin
		{clk, rst_n, wr, rd, scw, byp} = '0;
		{addr, wd, scmd} = '0;
		lf = 16'd38738;
		n_errors = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdc(ADDR_PATTERN_BASE, REG_RESET);
		sleep_cmd(SLEEP_ENTER_CODE, 1'b1);
		sleep_cmd(SLEEP_EXIT_CODE, 1'b0);
		wrt(8'h50, 32'hffffffff);
		rdc(8'h50, 32'h0);
		for (int k = 0; k < 8; k++) begin
			lf = nx(lf);
			v[k] = {lf, nx(lf)} & (k == 4 ? 32'h0f0f0f0f : 32'hffffffff);
			if (k > 2)
				wrt(ADDR_PATTERN_BASE + 8'(4 * k), v[k]);
			else if (k == 0)
				wrt(ADDR_PATTERN_BASE, v[k]);
		end
		for (int k = 0; k < 8; k++)
			if (k == 0 || k > 2)
				rdc(ADDR_PATTERN_BASE + 8'(4 * k), v[k] & (k < 4 ? 32'h7fffffff : '1));
		for (int t = 0; t < 12; t++) begin
			lf = nx(lf);
			{ie, ok, bp, ps, fm, cm, en} = lf[6:0];
			if (t < 2)
				{en, fm, ps, ok, ie} = {1'b1, cm, 1'b1, 1'b1, t == 0};
			for (int i = 0; i < 60; i++) begin
				lf = nx(lf);
				PM.frame[i] = lf[7:0];
			end
			PM.frame[0][0] = fm;
			lf = nx(lf);
			m = {1'b0, lf[14:0], nx(lf)};
			off = 8'd13 + 8'(lf[2:0]);
			ex = en && cm == fm && (ps || bp) && ok;
			byp <= bp;
			wrt(ADDR_PATTERN_BASE, m);
			wrt(ADDR_PATTERN_BASE + 8'h10, {28'h0, cm, 2'b00, en});
			wrt(ADDR_PATTERN_BASE + 8'h14, {24'h0, off});
			wrt(ADDR_PATTERN_BASE + 8'h18, {16'h0, crc(off, m) ^ {15'h0, !ok}});
			wrt(ADDR_WAKE_CTRL, 32'h0);
			wrt(ADDR_WAKE_CTRL, {29'h0, 1'b1, 1'b0, ie});
			#1 chk1(slp, 1'b1);
			PM.send(60, ps, int'(lf[9]));
			saw = 1'b0;
			repeat (40) begin
				@(posedge clk);
				#1 saw = saw | (wk === 1'b1);
			end
			chk1(saw, ex);
			chk1(irq, ex && ie);
			chk1(slp, !ex);
		end
		// Signature frame: sync bytes then sixteen station addresses
		wrt(ADDR_WAKE_CTRL, 32'h0);
		wrt(ADDR_WAKE_CTRL, 32'h2);
		#1 chk1(slp, 1'b1);
		for (int i = 0; i < 116; i++)
			PM.frame[i] = (i < 14) ? 8'h00 : (i < 20) ? SIG_SYNC_BYTE :
				((i - 20) % 6 == 5) ? 8'h01 :
				((i - 20) % 6 == 0) ? 8'h02 : 8'h00;
		PM.send(116, 1'b0, 0);
		saw = 1'b0;
		repeat (40) begin
			@(posedge clk);
			#1 saw = saw | (wk === 1'b1);
		end
		chk1(saw, 1'b1);
		chk1(slp, 1'b0);
		wrt(ADDR_WAKE_CTRL, 32'h0);
		#1 chk1(irq, 1'b0);
		wrap_up();
	end
endmodule
